// [design/ppfs_params.svh]
`ifndef PPFS_PARAMS_SVH
`define PPFS_PARAMS_SVH
// register offsets on the plain register port
`define PPFS_OFF_TIMER_DIR 4'h0
`define PPFS_OFF_TIMER_DATA 4'h1
`define PPFS_OFF_ANALOG_DATA 4'h2
`define PPFS_OFF_OSC_DIR 4'h3
`define PPFS_OFF_OSC_DATA 4'h4
// widths and reset values
`define PPFS_TIMER_PINS 5
`define PPFS_ANALOG_PINS 4
`define PPFS_OSC_PINS 2
`define PPFS_RST_DIR 8'h00
`define PPFS_RST_DATA 8'h00
// analog channel selects {ch2,ch1,ch0}, {ch2,scan,ch1,ch0} and {ch2,scan,ch1}
`define PPFS_CH3_SEL 3'h3
`define PPFS_CH2_SEL_SINGLE 4'h2
`define PPFS_CH2_SEL_SCAN 3'h3
`endif

// [design/ppfs_pkg.sv]
`default_nettype none
package ppfs_pkg;
  // timer pin function after selection
  typedef enum logic [1:0] {
    PPFS_FN_GPIO = 2'b00,
    PPFS_FN_TIMER = 2'b01,
    PPFS_FN_PWM = 2'b10
  } ppfs_fn_e;
  typedef logic [7:0] ppfs_byte_t;
endpackage
`default_nettype wire

// [design/ppfs_sync.sv]
`include "ppfs_params.svh"
`default_nettype none
module ppfs_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // levels
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta;
  // two flops; only the second one is visible to the read path
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule
`default_nettype wire

// [design/ppfs_port_pin_function_select.sv]
// Operation
// - pin d: pwm bit wins, io code 001/01x timer out, else gpio with capture
// - pin c: same selection with its own pwm bit, io field, direction
// - pin b: same selection using io field in lower io control register
// - pin a: no pwm; 001/01x timer out, else gpio feeding capture input
// - clock pin always feeds timer clock; direction 0 input, 1 output
// - analog port read returns four pin levels; upper bits reserved
// - analog port bit reads 0 when used as converter or compare input
// - pin 3 is channel 3 for select 011; compare upper when disable 0
// - pin 2 is channel 2 for 0010 or 011x; compare lower when disable 0
// - clock pin-mode settings beat osc port direction and data
// - osc direction bits: 1 output, 0 input, write-only, reset 0
// - osc data read: latch for outputs, pin level for inputs
// - osc data bits 1:0 stored, read/write, reset 0, drive outputs
// - pin 1: gpio when upper 0; clock out for 10; osc output for 11
// - pin 0: gpio when mode bit 0; oscillator input when 1
// - timer port direction: 1 output, 0 input, write-only, reset 0
// - timer port data read: latch or pin level; reserved bits read 0
//
// The address-and-strobe port and the address map were left to the implementer.
`include "ppfs_params.svh"
`default_nettype none
module ppfs_port_pin_function_select (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output ppfs_pkg::ppfs_byte_t o_rdata,
  // timer settings: pwm enables {d,c,b}, io fields {d,c,b,a}
  input wire logic [2:0] i_pwm_enable,
  input wire logic [11:0] i_io_select,
  input wire logic [3:0] i_timer_out,
  input wire logic [2:0] i_pwm_out,
  // timer port pins {d,c,b,a,clk}
  input wire logic [4:0] i_timer_pin,
  output logic [4:0] o_timer_pin,
  output logic [4:0] o_timer_pin_oe,
  output logic [3:0] o_timer_capture,
  output logic o_timer_clock_in,
  // analog port
  input wire logic [3:0] i_analog_pin,
  input wire logic [3:0] i_channel_select,
  input wire logic i_comparison_input_disable,
  output logic [3:0] o_analog_in_use,
  output logic o_upper_comparison_input,
  output logic o_lower_comparison_input,
  // oscillator port
  input wire logic [1:0] i_clock_pin_mode,
  input wire logic i_system_clock,
  input wire logic i_osc_drive,
  input wire logic [1:0] i_osc_pin,
  output logic [1:0] o_osc_pin,
  output logic [1:0] o_osc_pin_oe,
  output logic o_oscillator_input_pin,
  output logic o_osc_amp_enable
);
  import ppfs_pkg::*;

  logic [4:0] timer_port_direction;
  logic [4:0] timer_port_data;
  logic [1:0] osc_port_direction;
  logic [1:0] osc_port_data;
  logic [4:0] timer_sync;
  logic [3:0] analog_sync;
  logic [1:0] osc_sync;
  logic [3:0] analog_use;
  logic [7:0] next_rdata;
  logic [4:0] next_timer_pin;
  logic [4:0] next_timer_oe;
  logic [1:0] next_osc_pin;
  logic [1:0] next_osc_oe;
  logic [3:0] pwm_pins;
  ppfs_fn_e fn_sel [4];

  // pwm sources per pin slot {d,c,b,a}; pin a has none, so a zero fills its slot
  assign pwm_pins = {i_pwm_out, 1'b0};

  // decode of one timer pin; io codes 001 and 01x give timer output
  function automatic ppfs_fn_e pin_fn(input logic pwm, input logic [2:0] io);
    if (pwm) begin
      return PPFS_FN_PWM;
    end else if (!io[2] && (io[1] || io[0])) begin
      return PPFS_FN_TIMER;
    end else begin
      return PPFS_FN_GPIO;
    end
  endfunction

  // pin levels pass two flops before any read or peripheral use
  ppfs_sync #(.W(11)) u_sync (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_timer_pin, i_analog_pin, i_osc_pin}),
    .o_sync({timer_sync, analog_sync, osc_sync})
  );

  // direction registers are write-only and clear on reset
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      timer_port_direction <= 5'h00;
      osc_port_direction <= 2'h0;
    end else if (i_wr) begin
      if (i_addr == `PPFS_OFF_TIMER_DIR) begin
        timer_port_direction <= i_wdata[4:0];
      end
      if (i_addr == `PPFS_OFF_OSC_DIR) begin
        osc_port_direction <= i_wdata[1:0];
      end
    end
  end

  // output latches
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      timer_port_data <= 5'h00;
      osc_port_data <= 2'h0;
    end else if (i_wr) begin
      if (i_addr == `PPFS_OFF_TIMER_DATA) begin
        timer_port_data <= i_wdata[4:0];
      end
      if (i_addr == `PPFS_OFF_OSC_DATA) begin
        osc_port_data <= i_wdata[1:0];
      end
    end
  end

  // function of timer pins a..d; pin a has no pwm mode
  always_comb begin
    fn_sel[3] = pin_fn(i_pwm_enable[2], i_io_select[11:9]);
    fn_sel[2] = pin_fn(i_pwm_enable[1], i_io_select[8:6]);
    fn_sel[1] = pin_fn(i_pwm_enable[0], i_io_select[5:3]);
    fn_sel[0] = pin_fn(1'b0, i_io_select[2:0]);
  end

  // analog channel ownership; pins 1 and 0 are never marked in use
  always_comb begin
    analog_use = 4'h0;
    analog_use[3] = {i_channel_select[3], i_channel_select[1:0]} == `PPFS_CH3_SEL;
    analog_use[2] = (i_channel_select == `PPFS_CH2_SEL_SINGLE) ||
                    (i_channel_select[3:1] == `PPFS_CH2_SEL_SCAN);
  end

  // pin drive: gpio follows direction; timer and pwm drive regardless
  always_comb begin
    next_timer_pin = timer_port_data;
    next_timer_oe = timer_port_direction;
    for (int i = 0; i < 4; i++) begin
      if (fn_sel[i] == PPFS_FN_PWM) begin
        next_timer_oe[i+1] = 1'b1;
        next_timer_pin[i+1] = pwm_pins[i];
      end else if (fn_sel[i] == PPFS_FN_TIMER) begin
        next_timer_oe[i+1] = 1'b1;
        next_timer_pin[i+1] = i_timer_out[i];
      end
    end
  end

  // oscillator port: pin-mode bits take precedence over gpio settings
  always_comb begin
    next_osc_pin = osc_port_data;
    next_osc_oe = osc_port_direction;
    if (i_clock_pin_mode[1]) begin
      next_osc_oe[1] = 1'b1;
      next_osc_pin[1] = i_clock_pin_mode[0] ? i_osc_drive : i_system_clock;
    end
    if (i_clock_pin_mode[0]) begin
      next_osc_oe[0] = 1'b0;
      next_osc_pin[0] = 1'b0;
    end
  end

  // pin outputs registered so the top drives only from flops
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_timer_pin <= 5'h00;
      o_timer_pin_oe <= 5'h00;
      o_osc_pin <= 2'h0;
      o_osc_pin_oe <= 2'h0;
    end else begin
      o_timer_pin <= next_timer_pin;
      o_timer_pin_oe <= next_timer_oe;
      o_osc_pin <= next_osc_pin;
      o_osc_pin_oe <= next_osc_oe;
    end
  end

  // timer capture and clock inputs stay connected whatever the pin function
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_timer_capture <= 4'h0;
      o_timer_clock_in <= 1'b0;
      o_analog_in_use <= 4'h0;
      o_upper_comparison_input <= 1'b0;
      o_lower_comparison_input <= 1'b0;
      o_oscillator_input_pin <= 1'b0;
      o_osc_amp_enable <= 1'b0;
    end else begin
      o_timer_capture <= timer_sync[4:1];
      o_timer_clock_in <= timer_sync[0];
      o_analog_in_use <= analog_use;
      o_upper_comparison_input <= !i_comparison_input_disable && analog_sync[3];
      o_lower_comparison_input <= !i_comparison_input_disable && analog_sync[2];
      o_oscillator_input_pin <= i_clock_pin_mode[0] && osc_sync[0];
      o_osc_amp_enable <= i_clock_pin_mode[1] && i_clock_pin_mode[0];
    end
  end

  // read mux; latch for outputs, synchronised level for inputs
  always_comb begin
    next_rdata = 8'h00;
    unique case (i_addr)
      `PPFS_OFF_TIMER_DATA: begin
        next_rdata[4:0] = (timer_port_data & timer_port_direction) |
                          (timer_sync & ~timer_port_direction);
      end
      `PPFS_OFF_ANALOG_DATA: begin
        // bits in analog or compare use read zero
        next_rdata[3:0] = analog_sync & ~analog_use &
                          ~{~i_comparison_input_disable, ~i_comparison_input_disable,
                            2'b00};
      end
      `PPFS_OFF_OSC_DATA: begin
        next_rdata[1:0] = (osc_port_data & osc_port_direction) |
                          (osc_sync & ~osc_port_direction);
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // read data stands in the cycle after the strobe only
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? next_rdata : 8'h00;
    end
  end

  // timer pin selection; pwm and timer functions own the pin one cycle later
  AST_PWM_DRIVES: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_pwm_enable[2] |=> o_timer_pin_oe[4]) else $error("pwm pin d not driven");
  AST_PWM_D_DATA: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_pwm_enable[2] |=> o_timer_pin[4] == $past(i_pwm_out[2]))
    else $error("pwm pin d data wrong");
  AST_PIN_C_TIMER: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (!i_pwm_enable[1] && i_io_select[8:6] == 3'h1) |=> o_timer_pin_oe[3])
    else $error("pin c timer output not driven");
  AST_PIN_C_PWM: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_pwm_enable[1] |=> o_timer_pin_oe[3] && o_timer_pin[3] == $past(i_pwm_out[1]))
    else $error("pwm pin c wrong");
  AST_PIN_B_GPIO: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (!i_pwm_enable[0] && i_io_select[5]) |=> o_timer_pin_oe[2] == $past(timer_port_direction[2]))
    else $error("pin b gpio direction wrong");
  AST_PIN_B_PWM: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_pwm_enable[0] |=> o_timer_pin_oe[2] && o_timer_pin[2] == $past(i_pwm_out[0]))
    else $error("pwm pin b wrong");
  AST_PIN_A_TIMER: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_io_select[2:1] == 2'b01) |=> o_timer_pin[1] == $past(i_timer_out[0]))
    else $error("pin a timer data wrong");
  AST_PIN_A_GPIO: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_io_select[2] |=> o_timer_pin_oe[1] == $past(timer_port_direction[1]))
    else $error("pin a gpio direction wrong");
  AST_CLOCK_PIN_DIR: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    1'b1 |=> o_timer_pin_oe[0] == $past(timer_port_direction[0]))
    else $error("clock pin direction wrong");
  AST_CLOCK_FEED: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    1'b1 |=> o_timer_clock_in == $past(timer_sync[0]))
    else $error("timer clock input not fed");

  // analog port reads; pins in converter or compare use read zero
  AST_ANALOG_ZERO: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_rd && i_addr == `PPFS_OFF_ANALOG_DATA && !i_comparison_input_disable) |=>
    o_rdata[3:2] == 2'b00) else $error("compare pins not read as zero");
  AST_ANALOG_UPPER: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_rd && i_addr == `PPFS_OFF_ANALOG_DATA) |=> o_rdata[7:4] == 4'h0)
    else $error("reserved bits nonzero");
  AST_ANALOG_LOW: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_rd && i_addr == `PPFS_OFF_ANALOG_DATA) |=> o_rdata[1:0] == $past(analog_sync[1:0]))
    else $error("analog pin level read wrong");
  AST_CH3_ZERO: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_rd && i_addr == `PPFS_OFF_ANALOG_DATA && analog_use[3]) |=> !o_rdata[3])
    else $error("channel 3 pin not read as zero");
  AST_CH2_ZERO: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_rd && i_addr == `PPFS_OFF_ANALOG_DATA && analog_use[2]) |=> !o_rdata[2])
    else $error("channel 2 pin not read as zero");
  AST_UPPER_CMP: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_comparison_input_disable |=> !o_upper_comparison_input)
    else $error("upper compare fed while disabled");
  AST_LOWER_CMP: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_comparison_input_disable |=> !o_lower_comparison_input)
    else $error("lower compare fed while disabled");

  // oscillator port; pin-mode bits beat the gpio registers
  AST_OSC_MODE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_clock_pin_mode[0] |=> !o_osc_pin_oe[0]) else $error("osc input driven");
  AST_OSC_GPIO_DIR: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !i_clock_pin_mode[1] |=> o_osc_pin_oe[1] == $past(osc_port_direction[1]))
    else $error("osc pin 1 gpio direction wrong");
  AST_SYSTEM_CLOCK_OUTPUT: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clock_pin_mode == 2'b10) |=> o_osc_pin_oe[1] && o_osc_pin[1] == $past(i_system_clock))
    else $error("clock output wrong");
  AST_OSCILLATOR_OUTPUT_PIN_DRIVE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clock_pin_mode == 2'b11) |=> o_osc_pin_oe[1] && o_osc_pin[1] == $past(i_osc_drive))
    else $error("oscillator output wrong");
  AST_OSC_DATA_DRIVE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !i_clock_pin_mode[0] |=> o_osc_pin[0] == $past(osc_port_data[0]))
    else $error("osc pin 0 data wrong");
  AST_OSC_READ: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_rd && i_addr == `PPFS_OFF_OSC_DATA && osc_port_direction[1]) |=>
    o_rdata[1] == $past(osc_port_data[1])) else $error("osc latch read wrong");
  AST_OSC_READ_PIN: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_rd && i_addr == `PPFS_OFF_OSC_DATA && !osc_port_direction[0]) |=>
    o_rdata[0] == $past(osc_sync[0])) else $error("osc pin level read wrong");
  AST_OSC_DIR_ZERO: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_rd && i_addr == `PPFS_OFF_OSC_DIR) |=> o_rdata == 8'h00)
    else $error("write-only osc direction read nonzero");

  // timer port register reads
  AST_TIMER_RESERVED: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_rd && i_addr == `PPFS_OFF_TIMER_DATA) |=> o_rdata[7:5] == 3'h0)
    else $error("timer reserved bits nonzero");
  AST_TIMER_READ_LATCH: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_rd && i_addr == `PPFS_OFF_TIMER_DATA && timer_port_direction[4]) |=>
    o_rdata[4] == $past(timer_port_data[4])) else $error("timer latch read wrong");
  AST_TIMER_READ_PIN: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_rd && i_addr == `PPFS_OFF_TIMER_DATA && !timer_port_direction[1]) |=>
    o_rdata[1] == $past(timer_sync[1])) else $error("timer pin level read wrong");
  AST_TIMER_DIR_ZERO: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_rd && i_addr == `PPFS_OFF_TIMER_DIR) |=> o_rdata == 8'h00)
    else $error("write-only timer direction read nonzero");

  // main scenarios reached
  COV_PWM: cover property (@(posedge i_core_clk) i_pwm_enable[2] ##1 o_timer_pin_oe[4]);
  COV_OSC_RD: cover property (@(posedge i_core_clk) i_rd && i_addr == `PPFS_OFF_OSC_DATA);
  COV_SYSTEM_CLOCK_OUTPUT: cover property (@(posedge i_core_clk) i_clock_pin_mode == 2'b10);
  COV_CH3: cover property (@(posedge i_core_clk) analog_use[3] && !i_comparison_input_disable);
  COV_OSCILLATOR_OUTPUT_PIN: cover property (@(posedge i_core_clk) i_clock_pin_mode == 2'b11);
endmodule
`default_nettype wire

// [tb/ppfs_pin_model.sv]
`default_nettype none
module ppfs_pin_model (
  // device drive
  input wire logic [4:0] i_timer_drv,
  input wire logic [4:0] i_timer_oe,
  input wire logic [1:0] i_osc_drv,
  input wire logic [1:0] i_osc_oe,
  // outside world levels
  input wire logic [4:0] i_timer_ext,
  input wire logic [1:0] i_osc_ext,
  // resolved wire levels
  output logic [4:0] o_timer_wire,
  output logic [1:0] o_osc_wire
);
  timeunit 1ns;
  timeprecision 1ns;
  // driven pins show the device, released pins the outside level, never a stale value
  assign o_timer_wire = (i_timer_oe & i_timer_drv) | (~i_timer_oe & i_timer_ext);
  assign o_osc_wire = (i_osc_oe & i_osc_drv) | (~i_osc_oe & i_osc_ext);
endmodule
`default_nettype wire

// [tb/ppfs_port_pin_function_select_tb_top.sv]
`default_nettype none
module ppfs_port_pin_function_select_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ppfs_pkg::*;
  // stimulus, all valued at time zero
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [2:0] i_pwm_enable = 3'h0;
  logic [11:0] i_io_select = 12'h000;
  logic [3:0] i_timer_out = 4'h5;
  logic [2:0] i_pwm_out = 3'h2;
  logic [3:0] i_analog_pin = 4'hF;
  logic [3:0] i_channel_select = 4'h0;
  logic i_comparison_input_disable = 1'b1;
  logic [1:0] i_clock_pin_mode = 2'h0;
  logic i_system_clock = 1'b1;
  logic i_osc_drive = 1'b0;
  logic [4:0] tp_ext = 5'h08;
  logic [1:0] osc_ext = 2'h2;
  // observed
  ppfs_byte_t o_rdata;
  logic [4:0] tp_wire, o_timer_pin, o_timer_pin_oe;
  logic [3:0] o_timer_capture, o_analog_in_use;
  logic [1:0] osc_wire, o_osc_pin, o_osc_pin_oe;
  logic o_timer_clock_in, o_upper_comparison_input, o_lower_comparison_input;
  logic o_oscillator_input_pin, o_osc_amp_enable;
  int num_errors = 0;
  int num_checks = 0;

  ppfs_port_pin_function_select DUT (.i_core_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_pwm_enable, .i_io_select, .i_timer_out, .i_pwm_out, .i_timer_pin(tp_wire),
    .o_timer_pin, .o_timer_pin_oe, .o_timer_capture, .o_timer_clock_in, .i_analog_pin,
    .i_channel_select, .i_comparison_input_disable, .o_analog_in_use, .o_upper_comparison_input,
    .o_lower_comparison_input, .i_clock_pin_mode, .i_system_clock, .i_osc_drive,
    .i_osc_pin(osc_wire), .o_osc_pin, .o_osc_pin_oe, .o_oscillator_input_pin, .o_osc_amp_enable);

  ppfs_pin_model PINS (.i_timer_drv(o_timer_pin), .i_timer_oe(o_timer_pin_oe),
    .i_osc_drv(o_osc_pin), .i_osc_oe(o_osc_pin_oe), .i_timer_ext(tp_ext), .i_osc_ext(osc_ext),
    .o_timer_wire(tp_wire), .o_osc_wire(osc_wire));

  // free running core clock
  always #5 i_core_clk = ~i_core_clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask
  // covers pin register stage plus the two synchroniser stages
  task automatic settle;
    repeat (4) @(posedge i_core_clk);
    #1;
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #50000;
    num_errors++;
    final_report();
  end

  initial begin
    logic [4:0] eoe, epin;
    logic [3:0] cs;
    logic m3, m2, tm;
    repeat (2) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    rdchk(4'h1, 8'h00);
    rdchk(4'h4, 8'h02);
    rdchk(4'h0, 8'h00);
    rdchk(4'h3, 8'h00);
    rdchk(4'hF, 8'h00);
    wr(4'h0, 8'h15);
    wr(4'h1, 8'h1F);
    settle();
    rdchk(4'h1, 8'h1D);
    rdchk(4'h0, 8'h00);
    @(posedge i_core_clk);
    tp_ext <= 5'h02;
    settle();
    rdchk(4'h1, 8'h17);
    // every io code, then pwm mode on top of a gpio code
    for (int c = 0; c < 9; c++) begin
      tm = (c < 8) && (c[2:0] inside {3'h1, 3'h2, 3'h3});
      @(posedge i_core_clk);
      i_io_select <= {4{c[2:0]}};
      i_pwm_enable <= (c == 8) ? 3'h7 : 3'h0;
      settle();
      eoe = {tm ? 4'hF : 4'hA, 1'b1};
      epin = {tm ? i_timer_out : 4'hF, 1'b1};
      if (c == 8) begin
        eoe[4:2] = 3'h7;
        epin[4:2] = i_pwm_out;
      end
      chk({3'h0, o_timer_pin_oe}, {3'h0, eoe});
      chk({3'h0, o_timer_pin & eoe}, {3'h0, epin & eoe});
      chk({3'h0, o_timer_capture, o_timer_clock_in}, {3'h0, tp_wire});
    end
    // all channel selects with compare input on and off
    for (int c = 0; c < 32; c++) begin
      @(posedge i_core_clk);
      i_channel_select <= c[3:0];
      i_comparison_input_disable <= c[4];
      settle();
      cs = c[3:0];
      m3 = !c[4] || (!cs[3] && cs[1:0] == 2'h3);
      m2 = !c[4] || cs == 4'h2 || cs[3:1] == 3'h3;
      rdchk(4'h2, {4'h0, !m3, !m2, 2'h3});
      chk({6'h0, o_upper_comparison_input, o_lower_comparison_input}, {6'h0, {2{!c[4]}}});
      chk({4'h0, o_analog_in_use},
        {4'h0, !cs[3] && cs[1:0] == 2'h3, cs == 4'h2 || cs[3:1] == 3'h3, 2'h0});
    end
    wr(4'h3, 8'h03);
    wr(4'h4, 8'h01);
    settle();
    chk({4'h0, o_osc_pin_oe, o_osc_pin & o_osc_pin_oe}, 8'h0D);
    rdchk(4'h4, 8'h01);
    wr(4'h3, 8'h01);
    settle();
    rdchk(4'h4, 8'h03);
    rdchk(4'h3, 8'h00);
    @(posedge i_core_clk);
    osc_ext <= 2'h1;
    // clock pin modes override the gpio settings just made
    for (int m = 1; m < 4; m++) begin
      @(posedge i_core_clk);
      i_clock_pin_mode <= m[1:0];
      settle();
      chk({5'h0, o_osc_pin_oe[0], o_oscillator_input_pin, o_osc_amp_enable},
        {5'h0, !m[0], m[0], m == 3});
      chk({6'h0, o_osc_pin_oe[1], o_osc_pin[1] & o_osc_pin_oe[1]},
        {6'h0, m[1], m[1] && m != 3});
    end
    final_report();
  end
endmodule
`default_nettype wire
